/* hw/annp_pr_latch.sv */
/*
 * annp_pr_latch: latch-high page-received flag with clear on read and the
 * alternate clearing mode.
 * assumes all inputs come from logic on the same clock and reset.
 */
`default_nettype none

module annp_pr_latch
  import annp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_pulse,
  input wire logic rd_clear,
  input wire logic alt_en,
  input wire logic mr_page_rx,
  input wire logic tx_disable,
  output logic flag
);

  logic flag_reg;
  logic flag_next;
  logic alt_clear;

  //////////////////////////////////////////////////////////////////////////
  // next flag: set wins over every clear so no page is missed
  always_comb begin
    alt_clear = alt_en && (!mr_page_rx || tx_disable);
    flag_next = flag_reg;
    if (rd_clear || alt_clear) begin
      flag_next = 1'b0;
    end
    if (set_pulse) begin
      flag_next = 1'b1;
    end
  end

  // flag register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_alt_cond;
    alt_en && (!mr_page_rx || tx_disable) && !set_pulse;
  endsequence

  sequence s_flag_low;
    !flag;
  endsequence

  chk_pr_set_latch: assert property (set_pulse |=> flag)
    else $error("page received not set");
  chk_pr_read_clear: assert property (rd_clear && !set_pulse |=> !flag)
    else $error("page received not cleared by read");
  chk_pr_alt_clear: assert property (s_alt_cond |=> s_flag_low)
    else $error("alternate clear failed");
  chk_pr_holds_high: assert property (
    flag && !rd_clear && !(alt_en && (!mr_page_rx || tx_disable)) |=> flag)
    else $error("page received dropped without clear");

endmodule : annp_pr_latch

`default_nettype wire

/* hw/annp_regs.sv */
/*
 * annp_regs: per-port auto-negotiation next-page register bank: partner
 * base page, expansion status, next-page transmit, partner next page and
 * the alternate next-page enable of the port configuration register.
 * assumes the management frame engine and the arbitration logic run on
 * sys_clk; nrst is asynchronous and is released here through two flops.
 */
`default_nettype none

module annp_regs
  import annp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_rd,
  output logic [15:0] mgmt_rdata,
  input wire logic page_rx_strobe,
  input wire logic [15:0] page_rx_word,
  input wire logic page_rx_is_base,
  input wire logic lp_an_able,
  input wire logic lp_np_able,
  input wire logic mr_page_rx,
  input wire logic transmit_disable,
  input wire logic lcw_sent,
  input wire logic lcw_sent_toggle,
  output logic [15:0] np_tx_word,
  output logic page_received
);

  //////////////////////////////////////////////////////////////////////////
  // reset release: asynchronous assert, two-flop synchronous release
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  //////////////////////////////////////////////////////////////////////////
  // address decode shared by read and write paths
  function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] off);
    addr_hit = (addr == off);
  endfunction

  logic [15:0] base_reg, base_next;
  logic [15:0] nprx_reg, nprx_next;
  logic [15:0] nptx_reg, nptx_next;
  logic [15:0] rdata_reg, rdata_next;
  logic altnp_reg, altnp_next;
  logic lpan_reg, lpan_next;
  logic lpnp_reg, lpnp_next;
  logic pr_set_reg, pr_set_next;
  logic pr_flag;
  logic exp_rd;
  logic [15:0] exp_word;

  //////////////////////////////////////////////////////////////////////////
  // expansion status word as software sees it
  always_comb begin
    exp_word = ANNP_WORD_ZERO;
    exp_word[ANNP_EXP_LPNP] = lpnp_reg;
    exp_word[ANNP_EXP_NPA] = ANNP_LOCAL_NP_ABLE;
    exp_word[ANNP_EXP_PR] = pr_flag;
    exp_word[ANNP_EXP_LPAN] = lpan_reg;
  end

  assign exp_rd = mgmt_rd && addr_hit(mgmt_addr, ANNP_ADDR_EXP);

  //////////////////////////////////////////////////////////////////////////
  // partner-side capture: words land one cycle before the flag rises,
  // so a read that sees page-received always finds the new word
  always_comb begin
    base_next = base_reg;
    nprx_next = nprx_reg;
    pr_set_next = page_rx_strobe;
    if (page_rx_strobe && page_rx_is_base) begin
      base_next = page_rx_word;
    end
    if (page_rx_strobe && !page_rx_is_base) begin
      nprx_next = page_rx_word;
    end
    lpan_next = lp_an_able;
    lpnp_next = lp_np_able;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_reg <= ANNP_WORD_ZERO;
      nprx_reg <= ANNP_WORD_ZERO;
      pr_set_reg <= 1'b0;
      lpan_reg <= 1'b0;
      lpnp_reg <= 1'b0;
    end else begin
      base_reg <= base_next;
      nprx_reg <= nprx_next;
      pr_set_reg <= pr_set_next;
      lpan_reg <= lpan_next;
      lpnp_reg <= lpnp_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software-written state: transmit word and alternate enable;
  // only offsets 7 and 16 accept writes, all others are dropped
  always_comb begin
    nptx_next = nptx_reg;
    altnp_next = altnp_reg;
    if (mgmt_wr && addr_hit(mgmt_addr, ANNP_ADDR_NPTX)) begin
      nptx_next = mgmt_wdata & ANNP_NPTX_WMASK;
    end
    if (mgmt_wr && addr_hit(mgmt_addr, ANNP_ADDR_CFG)) begin
      altnp_next = mgmt_wdata[ANNP_CFG_ALTNP];
    end
    // a sent word beats a same-cycle write so the toggle never repeats
    if (lcw_sent) begin
      nptx_next[ANNP_NP_TOG] = !lcw_sent_toggle;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nptx_reg <= ANNP_NPTX_RST;
      altnp_reg <= ANNP_ALTNP_RST;
    end else begin
      nptx_reg <= nptx_next;
      altnp_reg <= altnp_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data: registered, held between reads, unmapped reads give zero
  always_comb begin
    rdata_next = rdata_reg;
    if (mgmt_rd) begin
      rdata_next = ANNP_WORD_ZERO;
      if (addr_hit(mgmt_addr, ANNP_ADDR_BASE)) begin
        rdata_next = base_reg;
      end
      if (addr_hit(mgmt_addr, ANNP_ADDR_EXP)) begin
        rdata_next = exp_word;
      end
      if (addr_hit(mgmt_addr, ANNP_ADDR_NPTX)) begin
        rdata_next = nptx_reg;
      end
      if (addr_hit(mgmt_addr, ANNP_ADDR_NPRX)) begin
        rdata_next = nprx_reg;
      end
      if (addr_hit(mgmt_addr, ANNP_ADDR_CFG)) begin
        rdata_next[ANNP_CFG_ALTNP] = altnp_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= ANNP_WORD_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // page-received latch; read clears after the old value is captured
  annp_pr_latch u_pr_latch (
    .clk(sys_clk),
    .rst_n(rst_n),
    .set_pulse(pr_set_reg),
    .rd_clear(exp_rd),
    .alt_en(altnp_reg),
    .mr_page_rx(mr_page_rx),
    .tx_disable(transmit_disable),
    .flag(pr_flag)
  );

  assign mgmt_rdata = rdata_reg;
  assign np_tx_word = nptx_reg;
  assign page_received = pr_flag;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_np_arrives;
    page_rx_strobe && !page_rx_is_base;
  endsequence

  sequence s_word_then_flag(logic [15:0] w);
    (nprx_reg == w) ##1 pr_flag;
  endsequence

  chk_np_store_first: assert property (
    s_np_arrives |=> s_word_then_flag($past(page_rx_word)))
    else $error("next page not stored before flag");
  chk_base_store: assert property (
    page_rx_strobe && page_rx_is_base |=> base_reg == $past(page_rx_word))
    else $error("base page not stored");
  chk_ro_write_drop: assert property (
    mgmt_wr && !page_rx_strobe && addr_hit(mgmt_addr, ANNP_ADDR_NPRX)
    |=> $stable(nprx_reg))
    else $error("write changed partner next page");
  chk_exp_read_bits: assert property (
    exp_rd |=> mgmt_rdata[ANNP_EXP_NPA] && mgmt_rdata[ANNP_EXP_PR] == $past(pr_flag)
    && mgmt_rdata[ANNP_EXP_LPAN] == $past(lpan_reg))
    else $error("expansion read wrong");
  chk_lpnp_follow: assert property (lp_np_able |=> exp_word[ANNP_EXP_LPNP])
    else $error("partner np able not reported");
  chk_toggle_invert: assert property (
    lcw_sent |=> np_tx_word[ANNP_NP_TOG] == !$past(lcw_sent_toggle))
    else $error("toggle not inverted");
  chk_altnp_cfg: assert property (
    mgmt_wr && addr_hit(mgmt_addr, ANNP_ADDR_CFG)
    |=> altnp_reg == $past(mgmt_wdata[ANNP_CFG_ALTNP]))
    else $error("alternate enable not written");
  chk_nptx_rsvd: assert property (np_tx_word[ANNP_NP_ACK] == 1'b0)
    else $error("reserved transmit bit set");

endmodule : annp_regs

`default_nettype wire

/* pkg/annp_pkg.sv */
/*
 * annp_pkg: register offsets, bit positions and reset values of the
 * auto-negotiation next-page register bank.
 * assumes a 5-bit management register address and 16-bit register data.
 */
`default_nettype none

package annp_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register offsets on the management register port
  localparam logic [4:0] ANNP_ADDR_BASE = 5'h05; // partner base page
  localparam logic [4:0] ANNP_ADDR_EXP = 5'h06;  // expansion status
  localparam logic [4:0] ANNP_ADDR_NPTX = 5'h07; // next-page transmit
  localparam logic [4:0] ANNP_ADDR_NPRX = 5'h08; // partner next page
  localparam logic [4:0] ANNP_ADDR_CFG = 5'h10;  // port configuration

  //////////////////////////////////////////////////////////////////////////
  // expansion status bit positions
  localparam int ANNP_EXP_LPNP = 3; // partner next-page able
  localparam int ANNP_EXP_NPA = 2;  // local next-page able
  localparam int ANNP_EXP_PR = 1;   // page received
  localparam int ANNP_EXP_LPAN = 0; // partner auto-negotiation able

  // next-page word bit positions, shared by transmit and partner words
  localparam int ANNP_NP_NP = 15;
  localparam int ANNP_NP_ACK = 14;
  localparam int ANNP_NP_MP = 13;
  localparam int ANNP_NP_ACK2 = 12;
  localparam int ANNP_NP_TOG = 11;

  // port configuration bit position
  localparam int ANNP_CFG_ALTNP = 1;

  //////////////////////////////////////////////////////////////////////////
  // reset values and masks
  localparam logic [15:0] ANNP_NPTX_RST = 16'h2001; // mp set, code field 1
  localparam logic [15:0] ANNP_NPTX_WMASK = 16'hbfff; // bit 14 reads zero
  localparam logic [15:0] ANNP_WORD_ZERO = 16'h0000;
  localparam logic ANNP_LOCAL_NP_ABLE = 1'b1;
  localparam logic ANNP_ALTNP_RST = 1'b0;

endpackage : annp_pkg

`default_nettype wire

/* sim/annp_partner_model.sv */
/* annp_partner_model: far side of the next-page bank, giving pages,
   sent words and arbitration levels.
   assumes one bench process calls its tasks just after a clock edge. */
`default_nettype none

module annp_partner_model (
  input wire logic sys_clk,
  output logic page_rx_strobe,
  output logic [15:0] page_rx_word,
  output logic page_rx_is_base,
  output logic lp_an_able,
  output logic lp_np_able,
  output logic mr_page_rx,
  output logic transmit_disable,
  output logic lcw_sent,
  output logic lcw_sent_toggle
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_tog = 1'b0;

  ////////////////////////////////////////////////////////////
  // quiet line at start
  initial begin
    {page_rx_strobe, page_rx_is_base, lcw_sent, lcw_sent_toggle} = 4'h0;
    {lp_an_able, lp_np_able, mr_page_rx, transmit_disable} = 4'h0;
    page_rx_word = 16'h0000;
  end

  // levels held by the partner and the arbitration
  task automatic set_levels(input logic an, input logic np, input logic pr, input logic td);
    {lp_an_able, lp_np_able, mr_page_rx, transmit_disable} = {an, np, pr, td};
  endtask

  // one whole page for one cycle; the word is scrambled once released
  task automatic send_page(input logic [15:0] w, input logic base);
    @(posedge sys_clk) #1;
    {page_rx_strobe, page_rx_is_base, page_rx_word} = {1'b1, base, w};
    @(posedge sys_clk) #1;
    {page_rx_strobe, page_rx_is_base, page_rx_word} = {1'b0, ~base, ~w};
  endtask

  // each sent word inverts the previous toggle
  task automatic send_lcw(output logic t);
    @(posedge sys_clk) #1;
    last_tog = ~last_tog;
    {lcw_sent, lcw_sent_toggle} = {1'b1, last_tog};
    t = last_tog;
    @(posedge sys_clk) #1;
    {lcw_sent, lcw_sent_toggle} = {1'b0, ~last_tog};
  endtask
endmodule // annp_partner_model

`default_nettype wire

/* sim/testbench.sv */
/* testbench: register calls against annp_regs with expected words.
   assumes annp_pkg and the partner model are compiled first. */
`default_nettype none

module testbench
  import annp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, nrst, mgmt_wr, mgmt_rd, t;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, np_tx_word;
  wire logic strb, base, an, np, pr, td, sent, stog, page_received;
  wire logic [15:0] word;
  int failures, n_checks;

  annp_regs i_dut (.sys_clk(sys_clk), .nrst(nrst), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rd(mgmt_rd),
    .mgmt_rdata(mgmt_rdata), .page_rx_strobe(strb), .page_rx_word(word),
    .page_rx_is_base(base), .lp_an_able(an), .lp_np_able(np), .mr_page_rx(pr),
    .transmit_disable(td), .lcw_sent(sent), .lcw_sent_toggle(stog),
    .np_tx_word(np_tx_word), .page_received(page_received));
  annp_partner_model i_lp (.sys_clk(sys_clk), .page_rx_strobe(strb),
    .page_rx_word(word), .page_rx_is_base(base), .lp_an_able(an), .lp_np_able(np),
    .mr_page_rx(pr), .transmit_disable(td), .lcw_sent(sent), .lcw_sent_toggle(stog));

  ////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // one write strobe, effect lands on the next edge
  task automatic mgmt_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk) #1;
    {mgmt_wr, mgmt_addr, mgmt_wdata} = {1'b1, a, d};
    @(posedge sys_clk) #1;
    mgmt_wr = 1'b0;
  endtask

  // read strobe, then sample a cycle late since the data stands
  task automatic rd_chk(input string n, input logic [4:0] a, input logic [15:0] e);
    @(posedge sys_clk) #1;
    {mgmt_rd, mgmt_addr} = {1'b1, a};
    tick(1);
    mgmt_rd = 1'b0;
    tick(1);
    chk(n, e, mgmt_rdata);
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    $display("CHECK FAILED timeout expected end seen hang");
    print_verdict();
  end

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {nrst, mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = 24'h0;
    failures = 0;
    n_checks = 0;
    tick(20);
    nrst = 1'b1;
    tick(3);
    rd_chk("exp", ANNP_ADDR_EXP, 16'h0004);
    rd_chk("nptx", ANNP_ADDR_NPTX, 16'h2001);
    rd_chk("nprx", ANNP_ADDR_NPRX, 16'h0000);
    rd_chk("cfg", ANNP_ADDR_CFG, 16'h0000);
    rd_chk("unmapped", 5'h1f, 16'h0000);
    mgmt_write(ANNP_ADDR_NPTX, 16'hffff);
    rd_chk("nptx", ANNP_ADDR_NPTX, 16'hbfff);
    mgmt_write(ANNP_ADDR_NPTX, 16'h0000);
    chk("np_tx_word", 16'h0000, np_tx_word);
    // next page while page_rx is low: no alternate mode, flag holds
    i_lp.send_page(16'hf8aa, 1'b0);
    tick(2);
    chk("page_received", 16'h0001, {15'h0, page_received});
    rd_chk("nprx", ANNP_ADDR_NPRX, 16'hf8aa);
    mgmt_write(ANNP_ADDR_NPRX, 16'h0000);
    mgmt_write(ANNP_ADDR_EXP, 16'hffff);
    rd_chk("nprx", ANNP_ADDR_NPRX, 16'hf8aa);
    rd_chk("exp", ANNP_ADDR_EXP, 16'h0006);
    rd_chk("exp", ANNP_ADDR_EXP, 16'h0004);
    i_lp.set_levels(1'b1, 1'b1, 1'b1, 1'b0);
    tick(2);
    rd_chk("exp", ANNP_ADDR_EXP, 16'h000d);
    // base page goes to its own register only
    i_lp.send_page(16'h41e1, 1'b1);
    rd_chk("base", ANNP_ADDR_BASE, 16'h41e1);
    rd_chk("nprx", ANNP_ADDR_NPRX, 16'hf8aa);
    rd_chk("exp", ANNP_ADDR_EXP, 16'h000f);
    repeat (2) begin
      i_lp.send_lcw(t);
      chk("toggle", {15'h0, ~t}, {15'h0, np_tx_word[ANNP_NP_TOG]});
    end
    // alternate clearing, by page_rx low and by transmit disable
    mgmt_write(ANNP_ADDR_CFG, 16'hffff);
    rd_chk("cfg", ANNP_ADDR_CFG, 16'h0002);
    for (int i = 0; i < 2; i++) begin
      i_lp.send_page(16'h0123, 1'b0);
      tick(2);
      chk("page_received", 16'h0001, {15'h0, page_received});
      i_lp.set_levels(1'b1, 1'b1, i == 1, i == 1);
      tick(2);
      chk("page_received", 16'h0000, {15'h0, page_received});
      i_lp.set_levels(1'b1, 1'b1, 1'b1, 1'b0);
    end
    rd_chk("nprx", ANNP_ADDR_NPRX, 16'h0123);
    // mid-run reset with a pending flag, a written config and a toggled word
    i_lp.send_page(16'h0123, 1'b0);
    tick(2);
    chk("page_received", 16'h0001, {15'h0, page_received});
    nrst = 1'b0;
    i_lp.set_levels(1'b0, 1'b0, 1'b0, 1'b0);
    tick(2);
    chk("page_received", 16'h0000, {15'h0, page_received});
    chk("np_tx_word", 16'h2001, np_tx_word);
    chk("mgmt_rdata", 16'h0000, mgmt_rdata);
    nrst = 1'b1;
    tick(3);
    rd_chk("exp", ANNP_ADDR_EXP, 16'h0004);
    rd_chk("cfg", ANNP_ADDR_CFG, 16'h0000);
    rd_chk("nprx", ANNP_ADDR_NPRX, 16'h0000);
    print_verdict();
  end
endmodule // testbench

`default_nettype wire
